// [src/rcf_coef_regs.sv]
`timescale 1ns/1ps
module rcf_coef_regs (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic page_sel, // high while the second page is selected
   input wire logic wr_en, // one-cycle write strobe
   input wire logic [6:0] addr, // register address
   input wire logic [7:0] wr_data, // write byte
   input wire logic rd_en, // one-cycle read strobe
   output logic [7:0] rd_data, // read byte, valid cycle after rd_en
   output logic signed [15:0] effects_denominator_tap_five, // effects filter coefficient
   output logic signed [15:0] deemph_numerator_tap_zero, // de-emphasis coefficient
   output logic signed [15:0] deemph_numerator_tap_one, // de-emphasis coefficient
   output logic signed [15:0] deemph_denominator_tap_one, // de-emphasis coefficient
   output logic signed [15:0] spatial_atten_coef // 3-d attenuation coefficient
);
   // ***************************************************
   // address decode
   // ***************************************************
   // offset from the base; only meaningful inside the window
   function automatic logic [6:0] rel_idx(input logic [6:0] a);
      rel_idx = a - rcf_pkg::BASE_ADDR;
   endfunction

   function automatic logic in_window(input logic [6:0] a);
      in_window = (a >= rcf_pkg::BASE_ADDR) && (a <= rcf_pkg::LAST_ADDR);
   endfunction

   logic hit;
   logic [6:0] idx;
   logic [7:0] bytes [0:9];
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;

   // a write on the other page must not land here
   assign hit = page_sel && in_window(addr);
   assign idx = rel_idx(addr);

   // ***************************************************
   // byte storage
   // ***************************************************
   genvar g;
   generate
      for (g = 0; g < rcf_pkg::NUM_REGS; g++) begin : g_byte
         rcf_byte_reg #(
            .RESET_VALUE(rcf_pkg::RST_TABLE[g*8 +: 8])
         ) u_byte (
            .clk(clk),
            .rst_n(rst_n),
            .wr_en(wr_en && hit && (idx == 7'(g))),
            .wr_data(wr_data),
            .q(bytes[g])
         );
      end
   endgenerate

   // ***************************************************
   // read path
   // ***************************************************
   // unmapped reads give zero rather than stale data
   always_comb begin
      rd_data_next = rd_data_reg;
      if (rd_en) begin
         if (hit) begin
            rd_data_next = bytes[idx[3:0]];
         end else begin
            rd_data_next = rcf_pkg::UNMAPPED_DATA;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_reg <= rcf_pkg::UNMAPPED_DATA;
      end else begin
         rd_data_reg <= rd_data_next;
      end
   end

   assign rd_data = rd_data_reg;

   // ***************************************************
   // coefficient assembly
   // ***************************************************
   // high byte at the lower address forms the upper half
   assign effects_denominator_tap_five = $signed({bytes[0], bytes[1]});
   assign deemph_numerator_tap_zero = $signed({bytes[2], bytes[3]});
   assign deemph_numerator_tap_one = $signed({bytes[4], bytes[5]});
   assign deemph_denominator_tap_one = $signed({bytes[6], bytes[7]});
   assign spatial_atten_coef = $signed({bytes[8], bytes[9]});

   // ***************************************************
   // checks on the whole words and the read data
   // ***************************************************
   // word view of the five ports, so a loop can walk every coefficient
   logic [15:0] coef_word [0:4];

   assign coef_word[0] = effects_denominator_tap_five;
   assign coef_word[1] = deemph_numerator_tap_zero;
   assign coef_word[2] = deemph_numerator_tap_one;
   assign coef_word[3] = deemph_denominator_tap_one;
   assign coef_word[4] = spatial_atten_coef;

   // the high byte ends up in the upper half of its word
   AST_WRITE_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && page_sel && addr == rcf_pkg::SPATIAL_ATTEN_COEF_HIGH_OFS)
      |=> spatial_atten_coef[15:8] == $past(wr_data))
      else $error("high byte write not in coefficient upper half");

   // the low byte ends up in the lower half
   AST_WRITE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && page_sel && addr == rcf_pkg::RIGHT_EFFECTS_COEF_D5_LOW_OFS)
      |=> effects_denominator_tap_five[7:0] == $past(wr_data))
      else $error("low byte write not in coefficient lower half");

   // a set sign bit survives; nothing saturates the word
   AST_NEG_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && page_sel && addr == rcf_pkg::RIGHT_DEEMPH_COEF_N0_HIGH_OFS
      && wr_data == 8'h80) |=> deemph_numerator_tap_zero[15] == 1'b1)
      else $error("negative coefficient clipped");

   // read data is taken before a write on the same edge lands,
   // so the reference is the byte as it stood at the strobe
   AST_READBACK: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_en && page_sel && addr == rcf_pkg::RIGHT_DEEMPH_COEF_N1_LOW_OFS)
      |=> rd_data == $past(deemph_numerator_tap_one[7:0]))
      else $error("readback differs from stored byte");

   AST_READ_D1: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_en && page_sel && addr == rcf_pkg::RIGHT_DEEMPH_COEF_D1_HIGH_OFS)
      |=> rd_data == $past(deemph_denominator_tap_one[15:8]))
      else $error("d1 high readback wrong");

   // while page_sel is low these addresses belong to the other page
   AST_OTHER_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
      (wr_en && !page_sel) |=> $stable(spatial_atten_coef)
      && $stable(effects_denominator_tap_five))
      else $error("write on other page changed a coefficient");

   AST_READ_OFF_PAGE: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_en && !page_sel)
      |=> rd_data == rcf_pkg::UNMAPPED_DATA)
      else $error("read on other page not zero");

   // addresses outside the window read as the filler byte
   AST_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
      (rd_en && (addr < rcf_pkg::BASE_ADDR || addr > rcf_pkg::LAST_ADDR))
      |=> rd_data == rcf_pkg::UNMAPPED_DATA)
      else $error("unmapped read not zero");

   // words move only on a write strobe
   AST_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
      !wr_en |=> $stable(deemph_numerator_tap_one) && $stable(deemph_denominator_tap_one))
      else $error("coefficient changed without a write");

   // read data stands until the next read strobe
   AST_RD_STANDS: assert property (@(posedge clk) disable iff (!rst_n)
      !rd_en |=> $stable(rd_data))
      else $error("read data changed without a read");

   // reset values, seen at the first edge after release; no disable here,
   // the antecedent itself needs the reset edge
   AST_RESET_VAL: assert property (@(posedge clk)
      $rose(rst_n) |-> effects_denominator_tap_five == 16'sh84ee
      && deemph_numerator_tap_zero == 16'sh3955 && deemph_numerator_tap_one == 16'shf32d
      && deemph_denominator_tap_one == 16'sh537e && spatial_atten_coef == 16'sh7fff)
      else $error("reset value wrong");

   AST_RD_RESET: assert property (@(posedge clk)
      $rose(rst_n) |-> rd_data == rcf_pkg::UNMAPPED_DATA)
      else $error("read data not cleared by reset");

   // ***************************************************
   // checks on every byte and every word
   // ***************************************************
   generate
      for (g = 0; g < rcf_pkg::NUM_REGS; g++) begin : g_chk_byte
         // a mapped write to this address lands in this byte
         AST_BYTE_TAKE: assert property (@(posedge clk) disable iff (!rst_n)
            (wr_en && page_sel && addr == 7'(rcf_pkg::BASE_ADDR + g))
            |=> bytes[g] == $past(wr_data))
            else $error("mapped write did not land in its byte");

         // no other access moves it, whatever the decode does
         AST_BYTE_KEEP: assert property (@(posedge clk) disable iff (!rst_n)
            !(wr_en && page_sel && addr == 7'(rcf_pkg::BASE_ADDR + g))
            |=> $stable(bytes[g]))
            else $error("byte changed without its own write");

         // a mapped read returns the byte as it stood at the strobe
         AST_BYTE_READ: assert property (@(posedge clk) disable iff (!rst_n)
            (rd_en && page_sel && addr == 7'(rcf_pkg::BASE_ADDR + g))
            |=> rd_data == $past(bytes[g]))
            else $error("read did not return the stored byte");

         // the byte leaves reset at its own reset value
         AST_BYTE_RESET: assert property (@(posedge clk)
            $rose(rst_n) |-> bytes[g] == rcf_pkg::RST_TABLE[g*8 +: 8])
            else $error("byte not at its reset value");
      end

      for (g = 0; g < rcf_pkg::NUM_COEFS; g++) begin : g_chk_word
         // high byte at the odd offset (BASE_ADDR + 2*g), low byte at the one after
         AST_WORD_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
            (wr_en && page_sel && addr == 7'(rcf_pkg::BASE_ADDR + 2*g))
            |=> coef_word[g][15:8] == $past(wr_data))
            else $error("high byte not in upper half of its word");

         AST_WORD_LOW: assert property (@(posedge clk) disable iff (!rst_n)
            (wr_en && page_sel && addr == 7'(rcf_pkg::BASE_ADDR + 2*g + 1))
            |=> coef_word[g][7:0] == $past(wr_data))
            else $error("low byte not in lower half of its word");

         // the sign of the word is the top bit of its high byte
         AST_WORD_SIGN: assert property (@(posedge clk) disable iff (!rst_n)
            (wr_en && page_sel && addr == 7'(rcf_pkg::BASE_ADDR + 2*g) && wr_data[7])
            |=> coef_word[g][15] == 1'b1)
            else $error("negative word lost its sign");
      end
   endgenerate
endmodule

// [src/rcf_pkg.sv]
package rcf_pkg;
   // ***************************************************
   // register map and reset values
   // ***************************************************
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int COEF_W = 16;
   localparam int NUM_REGS = 10;
   localparam int NUM_COEFS = 5;
   localparam logic [6:0] BASE_ADDR = 7'h2d;
   localparam logic [6:0] LAST_ADDR = 7'h36;
   localparam logic [6:0] RIGHT_EFFECTS_COEF_D5_HIGH_OFS = 7'h2d;
   localparam logic [6:0] RIGHT_EFFECTS_COEF_D5_LOW_OFS = 7'h2e;
   localparam logic [6:0] RIGHT_DEEMPH_COEF_N0_HIGH_OFS = 7'h2f;
   localparam logic [6:0] RIGHT_DEEMPH_COEF_N0_LOW_OFS = 7'h30;
   localparam logic [6:0] RIGHT_DEEMPH_COEF_N1_HIGH_OFS = 7'h31;
   localparam logic [6:0] RIGHT_DEEMPH_COEF_N1_LOW_OFS = 7'h32;
   localparam logic [6:0] RIGHT_DEEMPH_COEF_D1_HIGH_OFS = 7'h33;
   localparam logic [6:0] RIGHT_DEEMPH_COEF_D1_LOW_OFS = 7'h34;
   localparam logic [6:0] SPATIAL_ATTEN_COEF_HIGH_OFS = 7'h35;
   localparam logic [6:0] SPATIAL_ATTEN_COEF_LOW_OFS = 7'h36;
   // reset bytes, indexed by (offset - BASE_ADDR)
   localparam logic [7:0] RST_D5_HIGH = 8'h84;
   localparam logic [7:0] RST_D5_LOW = 8'hee;
   localparam logic [7:0] RST_N0_HIGH = 8'h39;
   localparam logic [7:0] RST_N0_LOW = 8'h55;
   localparam logic [7:0] RST_N1_HIGH = 8'hf3;
   localparam logic [7:0] RST_N1_LOW = 8'h2d;
   localparam logic [7:0] RST_D1_HIGH = 8'h53;
   localparam logic [7:0] RST_D1_LOW = 8'h7e;
   localparam logic [7:0] RST_ATTEN_HIGH = 8'h7f;
   localparam logic [7:0] RST_ATTEN_LOW = 8'hff;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   localparam logic [79:0] RST_TABLE = {RST_ATTEN_LOW, RST_ATTEN_HIGH, RST_D1_LOW,
      RST_D1_HIGH, RST_N1_LOW, RST_N1_HIGH, RST_N0_LOW, RST_N0_HIGH, RST_D5_LOW, RST_D5_HIGH};
endpackage

// [src/rcf_byte_reg.sv]
`timescale 1ns/1ps
// ***************************************************
// one read/write coefficient byte
// ***************************************************
module rcf_byte_reg #(
   parameter logic [7:0] RESET_VALUE = 8'h00
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic wr_en, // write strobe for this byte
   input wire logic [7:0] wr_data, // byte to store
   output logic [7:0] q // stored byte
);
   // every bit pattern kept as written, no clipping
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RESET_VALUE;
      end else if (wr_en) begin
         q <= wr_data;
      end
   end
endmodule

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
   // ***************************************************
   // stimulus, outputs and bookkeeping
   // ***************************************************
   logic clk = 1'b0;
   logic rst_n = 1'b1; // starts high so reset entry is a real falling edge
   logic page_sel = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_data;
   logic signed [15:0] coef [5];
   logic [7:0] rst_b [10] = '{8'h84, 8'hee, 8'h39, 8'h55, 8'hf3, 8'h2d, 8'h53, 8'h7e,
      8'h7f, 8'hff};
   int err_count = 0;
   int checks_done = 0;
   // free-running 100 mhz clock
   always #5 clk = ~clk;
   rcf_coef_regs rcf_coef_regs_i (
      .clk(clk),
      .rst_n(rst_n),
      .page_sel(page_sel),
      .wr_en(wr_en),
      .addr(addr),
      .wr_data(wr_data),
      .rd_en(rd_en),
      .rd_data(rd_data),
      .effects_denominator_tap_five(coef[0]),
      .deemph_numerator_tap_zero(coef[1]),
      .deemph_numerator_tap_one(coef[2]),
      .deemph_denominator_tap_one(coef[3]),
      .spatial_atten_coef(coef[4])
   );
   // ***************************************************
   // access tasks and comparison
   // ***************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // strobes stay up on return so back-to-back calls never assign twice in a step
   task automatic acc(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
      wr_en = w;
      rd_en = r;
      addr = a;
      wr_data = d;
      @(posedge clk);
      #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp);
      acc(1'b0, 1'b1, a, 8'h00);
      chk({8'h00, rd_data}, {8'h00, exp});
   endtask
   task automatic chk_reset();
      for (int i = 0; i < 10; i++) begin
         rd(rcf_pkg::BASE_ADDR + 7'(i), rst_b[i]);
      end
      for (int k = 0; k < 5; k++) begin
         chk(coef[k], {rst_b[2*k], rst_b[2*k+1]});
      end
   endtask
   task automatic give_verdict();
      $display("mismatches %0d, comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // ***************************************************
   // test sequence
   // ***************************************************
   initial begin
      #1 rst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      chk_reset();
      // extremes, then a distinct pattern per coefficient to expose decode slips
      for (int k = 0; k < 5; k++) begin
         acc(1'b1, 1'b0, rcf_pkg::BASE_ADDR + 7'(2*k), 8'h7f);
         acc(1'b1, 1'b0, rcf_pkg::BASE_ADDR + 7'(2*k+1), 8'hff);
         chk(coef[k], 16'h7fff);
         acc(1'b1, 1'b0, rcf_pkg::BASE_ADDR + 7'(2*k), 8'h80);
         acc(1'b1, 1'b0, rcf_pkg::BASE_ADDR + 7'(2*k+1), 8'h00);
         chk(coef[k], 16'h8000);
         acc(1'b1, 1'b0, rcf_pkg::BASE_ADDR + 7'(2*k+1), {5'h18, 3'(k)});
         chk(coef[k], {8'h80, 5'h18, 3'(k)});
         acc(1'b1, 1'b0, rcf_pkg::BASE_ADDR + 7'(2*k), {5'h10, 3'(k)});
      end
      for (int k = 0; k < 5; k++) begin
         chk(coef[k], {5'h10, 3'(k), 5'h18, 3'(k)});
         rd(rcf_pkg::BASE_ADDR + 7'(2*k), {5'h10, 3'(k)});
         rd(rcf_pkg::BASE_ADDR + 7'(2*k+1), {5'h18, 3'(k)});
      end
      // read and write of one byte in the same cycle returns the old byte
      acc(1'b1, 1'b1, 7'h35, 8'h5a);
      chk({8'h00, rd_data}, 16'h0084);
      rd(7'h35, 8'h5a);
      // off-page and out-of-window accesses leave the bank untouched
      page_sel = 1'b0;
      acc(1'b1, 1'b0, 7'h2d, 8'h11);
      rd(7'h2d, 8'h00);
      page_sel = 1'b1;
      acc(1'b1, 1'b0, 7'h2c, 8'h22);
      acc(1'b1, 1'b0, 7'h37, 8'h33);
      rd(7'h2c, 8'h00);
      rd(7'h37, 8'h00);
      rd(7'h2d, 8'h80);
      chk(coef[4], 16'h5ac4);
      // a second reset in mid-run restores every byte
      acc(1'b0, 1'b0, 7'h00, 8'h00);
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      chk_reset();
      acc(1'b0, 1'b0, 7'h00, 8'h00);
      give_verdict();
   end
   // watchdog, far beyond the ninety or so cycles the sequence needs
   initial begin
      #50000;
      err_count++;
      give_verdict();
   end
endmodule
